/* hw/loopback_test_map.svh */
// register map, field positions, reset values and timing figures of the loopback test controller
`ifndef LOOPBACK_TEST_MAP_SVH
`define LOOPBACK_TEST_MAP_SVH
`define CLK_HZ           40000000
`define TICK_S           1
`define REMOTE_SEND_S    10
`define TEST_TIMEOUT_MIN 10
`define TIMEOUT_RESET_S  (`TEST_TIMEOUT_MIN * 60)
`define CTRL_ADDR        8'h00
`define CONFIG_ADDR      8'h04
`define STATUS_ADDR      8'h08
`define ELAPSED_LO_ADDR  8'h0c
`define ELAPSED_HI_ADDR  8'h10
`define CMD_TERM_START   0
`define CMD_TERM_STOP    1
`define CMD_CHAN_START   2
`define CMD_CHAN_STOP    3
`define CMD_SEND         4
`define CMD_SEND_UP      5
`define CMD_LAMP_START   6
`define CMD_LAMP_STOP    7
`define CMD_ABORT        8
`define CMD_LINE_START   9
`define CFG_TIMEOUT_EN   0
`define ST_REFUSED       8
`define SEQ_UP_PATTERN   8'hf0
`define SEQ_DOWN_PATTERN 8'hcc
`define LED_COUNT        8
`define ELAPSED_W        16
`endif

/* hw/loopback_test_pkg.sv */
// types shared by the loopback test controller
package loopback_test_pkg;
  typedef enum logic [0:0] {
    ABORT_IDLE = 1'b0,
    ABORT_WAIT = 1'b1
  } abort_state_type;
  typedef logic [15:0] seconds_type;
endpackage

/* hw/seq_if.sv */
// carrier between the controller and the remote sequence generator
`timescale 1ns/10ps
`default_nettype none
interface seq_if;
  logic enable;
  logic up_sel;
  logic line_bit;
  modport gen (input enable, input up_sel, output line_bit);
  modport ctl (output enable, output up_sel, input line_bit);
endinterface
`default_nettype wire

/* hw/elapsed_timer.sv */
// per-test elapsed seconds counter, cleared while the test is idle
`timescale 1ns/10ps
`default_nettype none
`include "loopback_test_map.svh"
module elapsed_timer
(
  input  wire logic                         clk_i,
  input  wire logic                         rst_i,
  input  wire logic                         tick_i,
  input  wire logic                         run_i,
  output var  loopback_test_pkg::seconds_type secs_o
);
  loopback_test_pkg::seconds_type next_secs;

  always_comb
  begin
    next_secs = secs_o;
    if (!run_i)
      next_secs = '0;
    else if (tick_i && secs_o != '1) // saturate rather than wrap
      next_secs = secs_o + 16'h0001;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      secs_o <= '0;
    else
      secs_o <= next_secs;
  end

  AST_ELAPSED_COUNT: assert property (@(posedge clk_i) disable iff (rst_i)
    run_i && $past(run_i) && $past(tick_i) && $past(secs_o) != '1
      |-> secs_o == $past(secs_o) + 16'h0001)
    else $error("elapsed count did not advance on tick");
endmodule
`default_nettype wire

/* hw/seq_gen.sv */
// up/down sequence generator for the remote channel loopback request
`timescale 1ns/10ps
`default_nettype none
`include "loopback_test_map.svh"
module seq_gen
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  seq_if.gen        port
);
  logic [7:0] shift;
  logic [7:0] next_shift;

  always_comb
  begin
    // idle keeps the chosen pattern loaded so the first sent bit is its top bit
    next_shift = port.up_sel ? `SEQ_UP_PATTERN : `SEQ_DOWN_PATTERN;
    if (port.enable)
      next_shift = {shift[6:0], shift[7]};
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      shift <= `SEQ_DOWN_PATTERN;
    else
      shift <= next_shift;
  end

  assign port.line_bit = shift[7];

  sequence up_start;
    $rose(port.enable) && port.up_sel;
  endsequence

  // the fifth bit tells the up pattern from the down pattern
  sequence up_head;
    port.line_bit == 1'(`SEQ_UP_PATTERN >> 7) ##1 port.line_bit == 1'(`SEQ_UP_PATTERN >> 6)
      ##3 (!port.enable || port.line_bit == 1'(`SEQ_UP_PATTERN >> 3));
  endsequence

  AST_SEQ_UP_BITS: assert property (@(posedge clk_i) disable iff (rst_i)
    up_start |-> up_head)
    else $error("up sequence bits wrong");
endmodule
`default_nettype wire

/* hw/sync_port_loopback_test_ctrl.sv */
// loopback, remote sequence, lamp, timeout and abort control of the synchronous data port
`timescale 1ns/10ps
`default_nettype none
`include "loopback_test_map.svh"

module sync_port_loopback_test_ctrl
#(
  parameter int unsigned SEC_CYCLES = `CLK_HZ * `TICK_S
)
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        dte_txd_i,
  output logic             dte_rxd_o,
  input  wire logic        net_rxd_i,
  output logic             net_txd_o,
  input  wire logic        port_echo_active_i,
  input  wire logic        net_line_loop_active_i,
  input  wire logic        net_line_loop_by_net_i,
  input  wire logic        net_pattern_active_i,
  input  wire logic        net_user_tests_active_i,
  input  wire logic        remote_up_seen_i,
  input  wire logic        remote_down_seen_i,
  input  wire logic [7:0]  led_status_i,
  output logic      [7:0]  led_o,
  output logic             net_abort_o,
  output logic             line_loop_start_o,
  output logic             abort_done_o
);
  logic [31:0]                        sec_cnt, next_sec_cnt, next_dat;
  logic [9:0]                         cmd;
  logic [7:0]                         next_led;
  logic [3:0]                         run_vec;
  logic                               tick, wr, next_ack, term_ok, chan_ok, send_ok, line_ok;
  logic                               abort_go, term_to, chan_to, send_end;
  logic                               next_dte_rxd, next_net_txd;
  logic                               term, chan, chan_net, sending, up_sel, lamp, blink;
  logic                               refused, done, timeout_en;
  logic                               next_term, next_chan, next_chan_net, next_sending;
  logic                               next_up_sel, next_lamp, next_blink, next_refused, next_done;
  logic                               next_timeout_en, next_net_abort, next_line_start;
  logic                               next_abort_done;
  loopback_test_pkg::seconds_type     elapsed [4];
  loopback_test_pkg::seconds_type     timeout_secs, next_timeout_secs;
  loopback_test_pkg::abort_state_type abort_state, next_abort_state;

  seq_if sq ();

  seq_gen u_seq (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .port  (sq.gen)
  );
  assign sq.enable = sending;
  assign sq.up_sel = next_up_sel; // pattern must be loaded on the edge that starts the send
  // one-second enable for elapsed counts, lamp blink and the send duration
  assign tick = sec_cnt == 32'(SEC_CYCLES - 1);
  assign next_sec_cnt = tick ? '0 : sec_cnt + 32'h0000_0001;
  assign run_vec = {lamp, sending, chan, term};
  for (genvar i = 0; i < 4; i++)
  begin : g_elapsed
    elapsed_timer u_elapsed (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .tick_i (tick),
      .run_i  (run_vec[i]),
      .secs_o (elapsed[i])
    );
  end

  // wishbone: ack one cycle after the request, write acts on the ack edge
  assign wr  = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i;
  assign cmd = (wr && wb_adr_i == `CTRL_ADDR && wb_sel_i[1:0] == 2'h3) ? wb_dat_i[9:0] : 10'h000;

  always_comb
  begin
    next_ack = wb_cyc_i && wb_stb_i && !wb_ack_o;
    next_dat = 32'h0000_0000;
    unique case (wb_adr_i)
      `CONFIG_ADDR:     next_dat = {timeout_secs, 15'h0000, timeout_en};
      `STATUS_ADDR:     next_dat = {23'h000000, refused, done,
                                    abort_state == loopback_test_pkg::ABORT_WAIT,
                                    lamp, up_sel, sending, chan_net, chan, term};
      `ELAPSED_LO_ADDR: next_dat = {elapsed[1], elapsed[0]};
      `ELAPSED_HI_ADDR: next_dat = {elapsed[3], elapsed[2]};
      default:          next_dat = 32'h0000_0000;
    endcase
  end

  assign term_ok  = !port_echo_active_i && !chan && !sending;
  assign chan_ok  = !net_pattern_active_i && !net_line_loop_active_i
                    && !port_echo_active_i && !term;
  assign send_ok  = !net_pattern_active_i;
  assign line_ok  = !port_echo_active_i && !chan && !sending && !net_line_loop_by_net_i;
  assign abort_go = cmd[`CMD_ABORT] && abort_state == loopback_test_pkg::ABORT_IDLE;
  assign term_to  = timeout_en && term && elapsed[0] >= timeout_secs;
  assign chan_to  = timeout_en && chan && !chan_net && elapsed[1] >= timeout_secs;
  assign send_end = elapsed[2] >= 16'(`REMOTE_SEND_S);

  always_comb
  begin
    next_term         = term;
    next_chan         = chan;
    next_chan_net     = chan_net;
    next_sending      = sending;
    next_up_sel       = up_sel;
    next_lamp         = lamp;
    next_blink        = blink;
    next_refused      = refused;
    next_done         = done;
    next_timeout_en   = timeout_en;
    next_timeout_secs = timeout_secs;
    next_abort_state  = abort_state;
    next_net_abort    = 1'b0;
    next_line_start   = 1'b0;
    next_abort_done   = 1'b0;
    if (wr && wb_adr_i == `CONFIG_ADDR)
    begin
      if (wb_sel_i[0])
        next_timeout_en = wb_dat_i[`CFG_TIMEOUT_EN];
      if (wb_sel_i[2])
        next_timeout_secs[7:0] = wb_dat_i[23:16];
      if (wb_sel_i[3])
        next_timeout_secs[15:8] = wb_dat_i[31:24];
    end
    if (wr && wb_adr_i == `STATUS_ADDR && wb_sel_i[1] && wb_dat_i[`ST_REFUSED])
      next_refused = 1'b0;
    // terminal-side loopback
    if (cmd[`CMD_TERM_START] && !term)
    begin
      if (term_ok)
        next_term = 1'b1;
      else
        next_refused = 1'b1;
    end
    if (cmd[`CMD_TERM_STOP] || term_to || abort_go)
      next_term = 1'b0;
    // channel-side loopback, from the user or from a far-end up sequence
    if (cmd[`CMD_CHAN_START] && !chan)
    begin
      if (chan_ok)
      begin
        next_chan     = 1'b1;
        next_chan_net = 1'b0;
      end
      else
        next_refused = 1'b1;
    end
    else if (remote_up_seen_i && !chan && chan_ok)
    begin
      next_chan     = 1'b1;
      next_chan_net = 1'b1;
    end
    if (remote_down_seen_i || (!chan_net && (cmd[`CMD_CHAN_STOP] || chan_to || abort_go)))
    begin
      next_chan     = 1'b0;
      next_chan_net = 1'b0;
    end
    // remote sequence send has no manual stop; only its duration or abort ends it
    if (cmd[`CMD_SEND] && !sending)
    begin
      if (send_ok)
      begin
        next_sending = 1'b1;
        next_up_sel  = wb_dat_i[`CMD_SEND_UP];
      end
      else
        next_refused = 1'b1;
    end
    if (sending && (send_end || abort_go))
      next_sending = 1'b0;
    // lamp test
    if (cmd[`CMD_LAMP_START] && !lamp)
    begin
      next_lamp  = 1'b1;
      next_blink = 1'b1;
    end
    else if (lamp && tick)
      next_blink = !blink;
    if (cmd[`CMD_LAMP_STOP] || abort_go)
      next_lamp = 1'b0;
    if (cmd[`CMD_LINE_START])
    begin
      if (line_ok)
        next_line_start = 1'b1;
      else
        next_refused = 1'b1;
    end
    // abort: local tests stop at once, network side is asked and awaited
    unique case (abort_state)
      loopback_test_pkg::ABORT_IDLE:
        if (abort_go)
        begin
          next_abort_state = loopback_test_pkg::ABORT_WAIT;
          next_net_abort   = 1'b1;
          next_done        = 1'b0;
        end
      loopback_test_pkg::ABORT_WAIT:
        if (!net_abort_o && !net_user_tests_active_i && !term && !sending && !lamp
            && !(chan && !chan_net))
        begin
          next_abort_state = loopback_test_pkg::ABORT_IDLE;
          next_done        = 1'b1;
          next_abort_done  = 1'b1;
        end
    endcase
  end

  // data paths are registered; the loops sit right at the port flops
  always_comb
  begin
    next_dte_rxd = term ? dte_txd_i : net_rxd_i;
    next_net_txd = dte_txd_i;
    if (sending)
      next_net_txd = sq.line_bit;
    else if (chan)
      next_net_txd = net_rxd_i;
    next_led = lamp ? {`LED_COUNT{blink}} : led_status_i;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sec_cnt           <= '0;
      wb_ack_o          <= 1'b0;
      wb_dat_o          <= 32'h0000_0000;
      term              <= 1'b0;
      chan              <= 1'b0;
      chan_net          <= 1'b0;
      sending           <= 1'b0;
      up_sel            <= 1'b0;
      lamp              <= 1'b0;
      blink             <= 1'b0;
      refused           <= 1'b0;
      done              <= 1'b0;
      timeout_en        <= 1'b0;
      timeout_secs      <= 16'(`TIMEOUT_RESET_S);
      abort_state       <= loopback_test_pkg::ABORT_IDLE;
      net_abort_o       <= 1'b0;
      line_loop_start_o <= 1'b0;
      abort_done_o      <= 1'b0;
      dte_rxd_o         <= 1'b0;
      net_txd_o         <= 1'b0;
      led_o             <= 8'h00;
    end
    else
    begin
      sec_cnt           <= next_sec_cnt;
      wb_ack_o          <= next_ack;
      wb_dat_o          <= next_dat;
      term              <= next_term;
      chan              <= next_chan;
      chan_net          <= next_chan_net;
      sending           <= next_sending;
      up_sel            <= next_up_sel;
      lamp              <= next_lamp;
      blink             <= next_blink;
      refused           <= next_refused;
      done              <= next_done;
      timeout_en        <= next_timeout_en;
      timeout_secs      <= next_timeout_secs;
      abort_state       <= next_abort_state;
      net_abort_o       <= next_net_abort;
      line_loop_start_o <= next_line_start;
      abort_done_o      <= next_abort_done;
      dte_rxd_o         <= next_dte_rxd;
      net_txd_o         <= next_net_txd;
      led_o             <= next_led;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_TERM_LOOP: assert property (term |=> dte_rxd_o == $past(dte_txd_i))
    else $error("terminal loop data not returned");
  AST_TERM_REFUSE: assert property (cmd[`CMD_TERM_START] && !term && !term_ok
    |=> !term && refused)
    else $error("terminal loop started against exclusion");
  AST_CHAN_LOOP: assert property (chan && !sending |=> net_txd_o == $past(net_rxd_i))
    else $error("channel loop data not returned");
  AST_CHAN_REFUSE: assert property (!chan && !chan_ok |=> !chan)
    else $error("channel loop started against exclusion");
  AST_SEND_LIMIT: assert property (sending |-> elapsed[2] <= 16'(`REMOTE_SEND_S))
    else $error("remote sequence sent too long");
  AST_SEND_NO_STOP: assert property (sending && !send_end && !abort_go |=> sending)
    else $error("remote sequence ended early");
  AST_SEND_REFUSE: assert property (cmd[`CMD_SEND] && !sending && net_pattern_active_i
    |=> !sending)
    else $error("remote sequence started during pattern test");
  AST_LAMP_BLINK: assert property (lamp |=> led_o == {`LED_COUNT{$past(blink)}})
    else $error("lamp test indicators not blinking together");
  AST_LAMP_RESTORE: assert property (!rst_i && !lamp |=> led_o == $past(led_status_i))
    else $error("indicators not restored");
  AST_TIMEOUT: assert property (term_to && !cmd[`CMD_TERM_START] |=> !term)
    else $error("terminal loop outlived timeout");
  AST_NET_KEEP: assert property (chan && chan_net && !remote_down_seen_i |=> chan)
    else $error("network-started loop ended locally");
  sequence abort_issue;
    abort_go ##1 net_abort_o;
  endsequence
  AST_ABORT_FLOW: assert property (abort_issue |-> !term && !lamp && !sending
    && !abort_done_o)
    else $error("abort left a local test running");
  AST_ABORT_DONE: assert property (abort_done_o |-> !net_user_tests_active_i || $past(!net_user_tests_active_i))
    else $error("abort completed while far tests active");
  AST_LINE_REFUSE: assert property (cmd[`CMD_LINE_START] && !line_ok
    |=> !line_loop_start_o)
    else $error("line loop start passed against exclusion");
  AST_REFUSE_KEEPS: assert property (cmd[`CMD_CHAN_START] && !chan && !chan_ok
    && !remote_down_seen_i |=> chan == $past(chan) && term == $past(term))
    else $error("refused start changed state");
endmodule
`default_nettype wire

/* verification/far_side_model.sv */
// far-side model: terminal and remote unit bit streams, remote loop tracking
`timescale 1ns/10ps
`default_nettype none
module far_side_model
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic net_txd_i,
  output logic      dte_txd_o,
  output logic      net_rxd_o,
  output logic      far_loop_o
);
  logic [7:0] seen;
  logic [1:0] ph;
  // streams of period 2 and 3 never hold either sequence, so no false detection
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dte_txd_o  <= 1'b0;
      net_rxd_o  <= 1'b0;
      ph         <= 2'h0;
      seen       <= 8'h00;
      far_loop_o <= 1'b0;
    end
    else
    begin
      dte_txd_o <= ~dte_txd_o;
      ph        <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
      net_rxd_o <= (ph != 2'h2);
      seen      <= {seen[6:0], net_txd_i};
      if (seen == 8'hf0)
        far_loop_o <= 1'b1;
      else if (seen == 8'hcc)
        far_loop_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* verification/tb_sync_port_loopback_test_ctrl.sv */
// self-checking bench of the loopback test controller
`timescale 1ns/10ps
`default_nettype none
`include "loopback_test_map.svh"
module tb_sync_port_loopback_test_ctrl;
  localparam int SEC = 16;
  logic        clk_i, rst_i, cyc, stb, we, ack;
  logic [7:0]  adr, led, led_st;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat;
  logic        dte_txd, dte_rxd, net_rxd, net_txd, far_loop;
  logic        echo, lla, lbn, pat, uta, up_seen, down_seen, abort_o, line_o, done_o;
  int          mismatches, n_compared, n_line, n_abort, n_done;
  event        hang;

  sync_port_loopback_test_ctrl #(.SEC_CYCLES(SEC)) i_sync_port_loopback_test_ctrl
  (
    .clk_i                   (clk_i),
    .rst_i                   (rst_i),
    .wb_cyc_i                (cyc),
    .wb_stb_i                (stb),
    .wb_we_i                 (we),
    .wb_adr_i                (adr),
    .wb_sel_i                (sel),
    .wb_dat_i                (wdat),
    .wb_dat_o                (rdat),
    .wb_ack_o                (ack),
    .dte_txd_i               (dte_txd),
    .dte_rxd_o               (dte_rxd),
    .net_rxd_i               (net_rxd),
    .net_txd_o               (net_txd),
    .port_echo_active_i      (echo),
    .net_line_loop_active_i  (lla),
    .net_line_loop_by_net_i  (lbn),
    .net_pattern_active_i    (pat),
    .net_user_tests_active_i (uta),
    .remote_up_seen_i        (up_seen),
    .remote_down_seen_i      (down_seen),
    .led_status_i            (led_st),
    .led_o                   (led),
    .net_abort_o             (abort_o),
    .line_loop_start_o       (line_o),
    .abort_done_o            (done_o)
  );

  far_side_model i_far_side_model
  (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .net_txd_i  (net_txd),
    .dte_txd_o  (dte_txd),
    .net_rxd_o  (net_rxd),
    .far_loop_o (far_loop)
  );

  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    @(hang);
    print_verdict();
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one classic cycle; the answer is awaited, never assumed
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    int n;
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    if (n >= 20)
    begin
      mismatches++;
      -> hang;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0, q);
    check(q & m, e);
  endtask

  task automatic cmd(input int b);
    wr(`CTRL_ADDR, 32'h1 << b);
  endtask

  // output follows the looped input one cycle later
  task automatic loop_chk(input logic chan);
    logic p;
    @(posedge clk_i);
    p = chan ? net_rxd : dte_txd;
    repeat (8)
    begin
      @(posedge clk_i);
      check(chan ? net_txd : dte_rxd, p);
      p = chan ? net_rxd : dte_txd;
    end
  endtask

  // pulse outputs are counted so that a short pulse is never missed
  always @(posedge clk_i)
  begin
    if (line_o === 1'b1)
      n_line++;
    if (abort_o === 1'b1)
      n_abort++;
    if (done_o === 1'b1)
      n_done++;
  end

  initial
  begin
    logic [31:0] q;
    logic [7:0]  l0;
    {rst_i, sel, led_st} = {1'b1, 4'hf, 8'h5a};
    {cyc, stb, we, adr, wdat} = '0;
    {echo, lla, lbn, pat, uta, up_seen, down_seen} = '0;
    {mismatches, n_compared, n_line, n_abort, n_done} = '0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check({abort_o, line_o, done_o, led}, 32'h0);
    rd_chk(`CONFIG_ADDR, 32'hffffffff, 32'h02580000);
    rd_chk(`STATUS_ADDR, 32'hffffffff, 32'h0);
    wr(8'h20, 32'hffffffff);
    rd_chk(8'h20, 32'hffffffff, 32'h0);
    cmd(`CMD_TERM_START);
    rd_chk(`STATUS_ADDR, 32'h1, 32'h1);
    loop_chk(1'b0);
    cmd(`CMD_TERM_STOP);
    rd_chk(`STATUS_ADDR, 32'h1, 32'h0);
    echo <= 1'b1;
    cmd(`CMD_TERM_START);
    rd_chk(`STATUS_ADDR, 32'h101, 32'h100);
    echo <= 1'b0;
    wr(`STATUS_ADDR, 32'h100);
    cmd(`CMD_CHAN_START);
    rd_chk(`STATUS_ADDR, 32'h7, 32'h2);
    loop_chk(1'b1);
    cmd(`CMD_TERM_START);
    rd_chk(`STATUS_ADDR, 32'h103, 32'h102);
    wr(`STATUS_ADDR, 32'h100);
    cmd(`CMD_CHAN_STOP);
    rd_chk(`STATUS_ADDR, 32'h103, 32'h0);
    // each blocking condition alone, the last one being a running terminal loop
    for (int i = 0; i < 4; i++)
    begin
      pat  <= (i == 0);
      lla  <= (i == 1);
      echo <= (i == 2);
      if (i == 3)
        cmd(`CMD_TERM_START);
      cmd(`CMD_CHAN_START);
      rd_chk(`STATUS_ADDR, 32'h102, 32'h100);
      wr(`STATUS_ADDR, 32'h100);
    end
    {pat, lla, echo} <= 3'h0;
    cmd(`CMD_TERM_STOP);
    echo <= 1'b1;
    cmd(`CMD_LINE_START);
    repeat (4) @(posedge clk_i);
    check(n_line, 0);
    rd_chk(`STATUS_ADDR, 32'h100, 32'h100);
    echo <= 1'b0;
    wr(`STATUS_ADDR, 32'h100);
    cmd(`CMD_LINE_START);
    repeat (4) @(posedge clk_i);
    check(n_line, 1);
    lbn <= 1'b1;
    cmd(`CMD_LINE_START);
    repeat (4) @(posedge clk_i);
    check(n_line, 1);
    rd_chk(`STATUS_ADDR, 32'h100, 32'h100);
    lbn <= 1'b0;
    wr(`STATUS_ADDR, 32'h100);
    pat <= 1'b1;
    wr(`CTRL_ADDR, 32'h30);
    rd_chk(`STATUS_ADDR, 32'h108, 32'h100);
    pat <= 1'b0;
    wr(`STATUS_ADDR, 32'h100);
    // up then down; stop commands meanwhile must not cut the send short
    for (int k = 1; k >= 0; k--)
    begin
      wr(`CTRL_ADDR, (32'h1 << `CMD_SEND) | (k << `CMD_SEND_UP));
      rd_chk(`STATUS_ADDR, 32'h18, 32'h8 | (k << 4));
      cmd(`CMD_CHAN_STOP);
      cmd(`CMD_TERM_STOP);
      repeat (7 * SEC) @(posedge clk_i);
      rd_chk(`STATUS_ADDR, 32'h8, 32'h8);
      repeat (4 * SEC) @(posedge clk_i);
      rd_chk(`STATUS_ADDR, 32'h8, 32'h0);
      check(far_loop, k);
    end
    cmd(`CMD_LAMP_START);
    repeat (3) @(posedge clk_i);
    l0 = led;
    check(l0 == 8'hff || l0 == 8'h00, 1'b1);
    repeat (SEC) @(posedge clk_i);
    check(led, l0 ^ 8'hff);
    cmd(`CMD_LAMP_STOP);
    repeat (3) @(posedge clk_i);
    check(led, 8'h5a);
    wr(`CONFIG_ADDR, 32'h00030001);
    cmd(`CMD_TERM_START);
    repeat (20) @(posedge clk_i);
    xfer(1'b0, `ELAPSED_LO_ADDR, 32'h0, q);
    check(q[15:0] == 16'h1 || q[15:0] == 16'h2, 1'b1);
    rd_chk(`STATUS_ADDR, 32'h1, 32'h1);
    repeat (3 * SEC) @(posedge clk_i);
    rd_chk(`STATUS_ADDR, 32'h1, 32'h0);
    up_seen <= 1'b1;
    @(posedge clk_i);
    up_seen <= 1'b0;
    rd_chk(`STATUS_ADDR, 32'h6, 32'h6);
    repeat (5 * SEC) @(posedge clk_i);
    rd_chk(`STATUS_ADDR, 32'h6, 32'h6);
    // completion is held off while a remote-side test is still winding down
    uta <= 1'b1;
    cmd(`CMD_LAMP_START);
    cmd(`CMD_ABORT);
    repeat (8) @(posedge clk_i);
    check(n_abort, 1);
    check(n_done, 0);
    rd_chk(`STATUS_ADDR, 32'he6, 32'h46);
    uta <= 1'b0;
    repeat (8) @(posedge clk_i);
    check(n_done, 1);
    rd_chk(`STATUS_ADDR, 32'he6, 32'h86);
    down_seen <= 1'b1;
    @(posedge clk_i);
    down_seen <= 1'b0;
    rd_chk(`STATUS_ADDR, 32'h6, 32'h0);
    print_verdict();
  end
endmodule
`default_nettype wire
